// File: logic/pirdc_defs.svh
// register map, field positions, reset values and timing figures of the detector core
`ifndef PIRDC_DEFS_SVH
`define PIRDC_DEFS_SVH

`define PIRDC_ADDR_W 9
`define PIRDC_ADDR_CFG_A 9'h103
`define PIRDC_ADDR_CFG_B 9'h104
`define PIRDC_ADDR_STATUS 9'h10D

`define PIRDC_CFG_A_RESET 8'h00
`define PIRDC_CFG_B_RESET 8'h00

`define PIRDC_TICK_BIT 7
`define PIRDC_FREQ_HI 6
`define PIRDC_FREQ_LO 3
`define PIRDC_RATE_BIT 2
`define PIRDC_PULSE_BIT 1
`define PIRDC_DUAL_BIT 0
`define PIRDC_LIGHT_HI 7
`define PIRDC_LIGHT_LO 3
`define PIRDC_RANGE_HI 2
`define PIRDC_RANGE_LO 0

`define PIRDC_ST_MOTION 0
`define PIRDC_ST_LIGHT 1
`define PIRDC_ST_SUPPRESS 2
`define PIRDC_ST_POWER 3

`define PIRDC_NORMAL_CYC 256
`define PIRDC_LOW_CYC 5129
`define PIRDC_CLK_KHZ 100000
`define PIRDC_SETTLE_MS 200

`define PIRDC_THR_BASE 12'h020

`endif

// File: logic/pirdc_pkg.sv
// types shared by the detector core
`default_nettype none
package pirdc_pkg;
	typedef enum logic [0:0] {CONV_OFF, CONV_RUN} pirdc_conv_t;
endpackage
`default_nettype wire

// File: logic/pirdc_engine.sv
// configuration, scan control and motion qualification of the infrared detector core
// Function
// - engine polls tick, housekeeps, clears it
// - four-bit frequency response sets low-frequency acceptance
// - smaller frequency response also shortens range
// - normal rate: conversion every 256 clocks
// - low rate: single-shot conversion of 5129 clocks
// - converter powered off between low-rate conversions
// - low rate disables interference immunity
// - rate change suppresses detection up to 200ms
// - pulse bit selects one or two pulses
// - dual bit adds second sensor to scan
// - either sensor raises motion event
// - light threshold sets sensitivity, zero disables
// - light conversions single-ended buffered by engine
// - low power forces light detection off
// - motion flag sticky until application clears
// - range field shortens range as it grows
`timescale 1ns/1ps
`default_nettype none
`include "pirdc_defs.svh"
module pirdc_engine #(
	parameter int LOW_CYCLES = `PIRDC_LOW_CYC,
	parameter int SETTLE_CYCLES = `PIRDC_SETTLE_MS * `PIRDC_CLK_KHZ,
	parameter int SAMPLE_W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [`PIRDC_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// converter side
	input wire logic convStartReq,
	input wire logic lowPowerMode,
	input wire logic [SAMPLE_W-1:0] primarySensorInput,
	input wire logic [SAMPLE_W-1:0] secondSensorInput,
	input wire logic [SAMPLE_W-1:0] lightSenseInput,
	output logic convPowerOn,
	output logic convContinuous,
	output logic convBuffered,
	output logic selPrimary,
	output logic selSecond,
	output logic selLight,
	output logic sampleIrq,
	// engine status
	output logic housekeepingTick,
	output logic emiImmunity,
	output logic motionEvent,
	output logic motionDetected,
	output logic lightChanged
);

	if (LOW_CYCLES <= `PIRDC_NORMAL_CYC || LOW_CYCLES > 8192) $error("bad LOW_CYCLES");
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << 25)) $error("bad SETTLE_CYCLES");
	if (SAMPLE_W != 12) $error("SAMPLE_W must be 12");

	localparam logic [12:0] NORMAL_LAST = 13'(`PIRDC_NORMAL_CYC - 1);
	localparam logic [12:0] LOW_LAST = 13'(LOW_CYCLES - 1);
	localparam logic [24:0] SETTLE_LOAD = 25'(SETTLE_CYCLES);

	function automatic logic [11:0] absDiff(input logic [11:0] a, input logic [11:0] b);
		absDiff = (a > b) ? 12'(a - b) : 12'(b - a);
	endfunction

	// first-order baseline; a longer shift tracks slower and lets low frequencies through
	function automatic logic [11:0] track(input logic [11:0] base, input logic [11:0] s,
			input logic [2:0] sh);
		logic signed [12:0] diff;
		diff = $signed({1'b0, s}) - $signed({1'b0, base});
		track = 12'($signed({1'b0, base}) + (diff >>> sh));
	endfunction

	logic [7:0] cfgA;
	logic [7:0] cfgB;
	logic hkPulse;
	logic lowRateQ;
	pirdc_pkg::pirdc_conv_t convState;
	logic [12:0] convTimer;
	logic [24:0] suppressCnt;
	logic convLight;
	logic lightPending;
	logic [11:0] baseP;
	logic [11:0] baseS;
	logic [11:0] lightRef;
	logic lightRefValid;
	logic prevExceed;
	logic inPulse;
	logic pulseSeen;

	wire logic lowRate = cfgA[`PIRDC_RATE_BIT];
	wire logic twoPulse = cfgA[`PIRDC_PULSE_BIT];
	wire logic dualMode = cfgA[`PIRDC_DUAL_BIT];
	wire logic [3:0] freqResp = cfgA[`PIRDC_FREQ_HI:`PIRDC_FREQ_LO];
	wire logic [4:0] lightThr = cfgB[`PIRDC_LIGHT_HI:`PIRDC_LIGHT_LO];
	wire logic [2:0] rangeCtl = cfgB[`PIRDC_RANGE_HI:`PIRDC_RANGE_LO];
	wire logic modeChange = lowRate != lowRateQ;
	wire logic suppress = suppressCnt != 25'h0000000;
	wire logic lightOn = lightThr != 5'h00 && !lowPowerMode && !lowRate;
	wire logic wrA = regWrEn && regAddr == `PIRDC_ADDR_CFG_A;
	wire logic wrB = regWrEn && regAddr == `PIRDC_ADDR_CFG_B;
	wire logic wrSt = regWrEn && regAddr == `PIRDC_ADDR_STATUS;
	wire logic [12:0] lastCount = lowRate ? LOW_LAST : NORMAL_LAST;
	wire logic convDone = convState == pirdc_pkg::CONV_RUN && convTimer == lastCount;
	wire logic lowAccept = convState == pirdc_pkg::CONV_OFF && lowRate && convStartReq
		&& !modeChange;
	wire logic nextIsNew = lowAccept || (convDone && !lowRate);
	wire logic motionSample = convDone && !convLight;
	wire logic [2:0] trackShift = 3'({1'b0, freqResp[3:2]}) + 3'h1;
	// threshold grows with range and with a smaller frequency response
	wire logic [11:0] motionThr = `PIRDC_THR_BASE + 12'({rangeCtl, 4'h0})
		+ 12'({~freqResp, 1'b0});
	wire logic exceedP = absDiff(primarySensorInput, baseP) > motionThr;
	wire logic exceedS = dualMode && absDiff(secondSensorInput, baseS) > motionThr;
	wire logic exceed = (exceedP || exceedS) && !suppress;
	wire logic qualified = exceed && (lowRate || prevExceed);
	wire logic pulseEdge = motionSample && qualified && !inPulse;

	// configuration registers; a write carrying the tick wins over the engine clearing it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfgA <= `PIRDC_CFG_A_RESET;
		end else if (wrA) begin
			cfgA <= regWrData;
		end else if (hkPulse) begin
			cfgA[`PIRDC_TICK_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfgB <= `PIRDC_CFG_B_RESET;
		end else if (wrB) begin
			cfgB <= regWrData;
		end
	end

	// tick poll: one pulse per set state of the bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hkPulse <= 1'b0;
		end else begin
			hkPulse <= cfgA[`PIRDC_TICK_BIT] && !hkPulse;
		end
	end

	// registered copies: previous rate bit and the two event pulses
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lowRateQ <= 1'b0;
			sampleIrq <= 1'b0;
			housekeepingTick <= 1'b0;
		end else begin
			lowRateQ <= lowRate;
			sampleIrq <= convDone;
			housekeepingTick <= hkPulse;
		end
	end

	// converter sequencing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			convState <= pirdc_pkg::CONV_RUN;
			convTimer <= 13'h0000;
		end else if (modeChange) begin
			convState <= lowRate ? pirdc_pkg::CONV_OFF : pirdc_pkg::CONV_RUN;
			convTimer <= 13'h0000;
		end else begin
			unique case (convState)
				pirdc_pkg::CONV_OFF: begin
					if (lowAccept) begin
						convState <= pirdc_pkg::CONV_RUN;
					end
					convTimer <= 13'h0000;
				end
				pirdc_pkg::CONV_RUN: begin
					if (convDone) begin
						convTimer <= 13'h0000;
						if (lowRate) begin
							convState <= pirdc_pkg::CONV_OFF;
						end
					end else begin
						convTimer <= convTimer + 13'h0001;
					end
				end
			endcase
		end
	end

	// detection hold-off after a scan-rate change
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			suppressCnt <= 25'h0000000;
		end else if (modeChange) begin
			suppressCnt <= SETTLE_LOAD;
		end else if (suppress) begin
			suppressCnt <= suppressCnt - 25'h0000001;
		end
	end

	// light conversions are queued by housekeeping and take the next conversion slot
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lightPending <= 1'b0;
			convLight <= 1'b0;
		end else begin
			lightPending <= lightOn && ((lightPending && !nextIsNew) || hkPulse);
			if (nextIsNew) begin
				convLight <= lightPending && lightOn;
			end else if (!lightOn) begin
				convLight <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lightRef <= 12'h000;
			lightRefValid <= 1'b0;
			lightChanged <= 1'b0;
		end else begin
			if (convDone && convLight) begin
				lightRef <= lightSenseInput;
				lightRefValid <= 1'b1;
			end
			if (convDone && convLight && lightRefValid
					&& absDiff(lightSenseInput, lightRef) > 12'({lightThr, 4'h0})) begin
				lightChanged <= 1'b1;
			end else if (wrSt && regWrData[`PIRDC_ST_LIGHT]) begin
				lightChanged <= 1'b0;
			end
		end
	end

	// baselines follow the sensors on every motion conversion, the second sensor's only in dual mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			baseP <= 12'h800;
			baseS <= 12'h800;
		end else if (motionSample) begin
			baseP <= track(baseP, primarySensorInput, trackShift);
			if (dualMode) begin
				baseS <= track(baseS, secondSensorInput, trackShift);
			end
		end
	end

	// pulse qualification
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prevExceed <= 1'b0;
			inPulse <= 1'b0;
			pulseSeen <= 1'b0;
			motionEvent <= 1'b0;
		end else begin
			motionEvent <= 1'b0;
			if (motionSample) begin
				prevExceed <= exceed;
				inPulse <= qualified;
			end
			if (pulseEdge) begin
				if (!twoPulse || pulseSeen) begin
					motionEvent <= 1'b1;
					pulseSeen <= 1'b0;
				end else begin
					pulseSeen <= 1'b1;
				end
			end else if (hkPulse || !twoPulse) begin
				pulseSeen <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			motionDetected <= 1'b0;
		end else if (motionEvent) begin
			motionDetected <= 1'b1;
		end else if (wrSt && regWrData[`PIRDC_ST_MOTION]) begin
			motionDetected <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			unique case (regAddr)
				`PIRDC_ADDR_CFG_A: regRdData <= cfgA;
				`PIRDC_ADDR_CFG_B: regRdData <= cfgB;
				`PIRDC_ADDR_STATUS: regRdData <= {4'h0, convPowerOn, suppress,
					lightChanged, motionDetected};
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end

	assign convPowerOn = convState == pirdc_pkg::CONV_RUN;
	assign convContinuous = !lowRate;
	assign emiImmunity = !lowRate;
	assign selLight = convLight;
	assign convBuffered = convLight;
	assign selPrimary = !convLight;
	assign selSecond = !convLight && dualMode;

	// helper: cycles since the current conversion began
	logic [12:0] sinceStart;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sinceStart <= 13'h0000;
		end else if (nextIsNew || modeChange) begin
			sinceStart <= 13'h0000;
		end else begin
			sinceStart <= sinceStart + 13'h0001;
		end
	end

	conv_period_a: assert property (@(posedge clk) disable iff (reset)
		convDone && !$past(modeChange) |-> sinceStart == lastCount)
		else $error("conversion length wrong");
	power_off_a: assert property (@(posedge clk) disable iff (reset)
		convDone && lowRate && !modeChange |=> !convPowerOn)
		else $error("converter not powered off after low-rate conversion");
	emi_off_a: assert property (@(posedge clk) disable iff (reset)
		$rose(lowRate) |-> !emiImmunity ##1 !emiImmunity || !lowRate)
		else $error("immunity active in low rate");
	tick_clear_a: assert property (@(posedge clk) disable iff (reset)
		hkPulse && !wrA |=> !cfgA[`PIRDC_TICK_BIT])
		else $error("tick bit not cleared");
	tick_once_a: assert property (@(posedge clk) disable iff (reset)
		hkPulse |=> !hkPulse)
		else $error("double housekeeping tick");
	hold_off_a: assert property (@(posedge clk) disable iff (reset)
		modeChange |=> suppress [*8])
		else $error("no hold-off after rate change");
	light_off_a: assert property (@(posedge clk) disable iff (reset)
		lowPowerMode |=> !lightPending)
		else $error("light detection active in low power");
	motion_sticky_a: assert property (@(posedge clk) disable iff (reset)
		motionEvent |=> motionDetected)
		else $error("motion flag not set");
	two_pulse_a: assert property (@(posedge clk) disable iff (reset)
		$rose(motionEvent) && $past(twoPulse) |-> $past(pulseSeen))
		else $error("event on first pulse in two-pulse mode");
	light_buf_a: assert property (@(posedge clk) disable iff (reset)
		selLight |-> convBuffered && !selPrimary && !selSecond)
		else $error("light conversion not buffered");

	motion_seen_c: cover property (@(posedge clk) disable iff (reset) motionEvent);
	light_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(lightChanged));
	low_conv_c: cover property (@(posedge clk) disable iff (reset) convDone && lowRate);

endmodule
`default_nettype wire

// File: sim/pirdc_sensor_model.sv
// sensor and light-led model seen through the converter
`timescale 1ns/1ps
`default_nettype none
module pirdc_sensor_model (
	// converter state
	input wire logic convPowerOn,
	input wire logic selPrimary,
	input wire logic selSecond,
	input wire logic selLight,
	// scene
	input wire logic motionP,
	input wire logic motionS,
	input wire logic [11:0] lightLevel,
	// results
	output logic [11:0] primarySensorInput,
	output logic [11:0] secondSensorInput,
	output logic [11:0] lightSenseInput
);
	logic [11:0] pv, sv;
	assign pv = motionP ? 12'hF00 : 12'h800;
	assign sv = motionS ? 12'hF00 : 12'h800;
	// an unselected or unpowered channel shows the inverse, never a stale value
	assign primarySensorInput = (convPowerOn && selPrimary) ? pv : ~pv;
	assign secondSensorInput = (convPowerOn && selSecond) ? sv : ~sv;
	assign lightSenseInput = (convPowerOn && selLight) ? lightLevel : ~lightLevel;
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the detector engine
`timescale 1ns/1ps
`default_nettype none
`include "pirdc_defs.svh"
module testbench;
	localparam int LOWC = 300;
	localparam int SETC = 50;
	localparam logic [8:0] RA = `PIRDC_ADDR_CFG_A;
	localparam logic [8:0] RB = `PIRDC_ADDR_CFG_B;
	localparam logic [8:0] RS = `PIRDC_ADDR_STATUS;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [8:0] regAddr = 9'h000;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic convStartReq = 1'b0;
	logic lowPowerMode = 1'b0;
	logic motionP = 1'b0;
	logic motionS = 1'b0;
	logic [11:0] lightLevel = 12'h100;
	logic [7:0] regRdData, d;
	logic [11:0] pIn, sIn, lIn;
	logic convPowerOn, convContinuous, convBuffered, selPrimary, selSecond, selLight;
	logic sampleIrq, housekeepingTick, emiImmunity, motionEvent, motionDetected, lightChanged;
	int n_errors = 0;
	int n_tests = 0;
	int nHk = 0;
	int nEv = 0;
	int nLt = 0;
	int nBuf = 0;
	int c;
	always #5 clk = ~clk;
	pirdc_engine #(.LOW_CYCLES(LOWC), .SETTLE_CYCLES(SETC), .SAMPLE_W(12)) uut (
		.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.convStartReq(convStartReq), .lowPowerMode(lowPowerMode),
		.primarySensorInput(pIn), .secondSensorInput(sIn), .lightSenseInput(lIn),
		.convPowerOn(convPowerOn), .convContinuous(convContinuous),
		.convBuffered(convBuffered), .selPrimary(selPrimary), .selSecond(selSecond),
		.selLight(selLight), .sampleIrq(sampleIrq), .housekeepingTick(housekeepingTick),
		.emiImmunity(emiImmunity), .motionEvent(motionEvent),
		.motionDetected(motionDetected), .lightChanged(lightChanged));
	pirdc_sensor_model model (
		.convPowerOn(convPowerOn), .selPrimary(selPrimary), .selSecond(selSecond),
		.selLight(selLight), .motionP(motionP), .motionS(motionS),
		.lightLevel(lightLevel), .primarySensorInput(pIn),
		.secondSensorInput(sIn), .lightSenseInput(lIn));
	always @(negedge clk) begin
		nHk += int'(housekeepingTick === 1'b1);
		nEv += int'(motionEvent === 1'b1);
		nLt += int'(selLight === 1'b1);
		nBuf += int'(selLight === 1'b1 && convBuffered === 1'b1);
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chkn(input int g, input int e);
		n_tests++;
		if (g != e) begin
			n_errors++;
			$display("unexpected at %0t: count %0d want %0d", $time, g, e);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(negedge clk);
		v = regRdData;
		@(posedge clk);
	endtask
	task automatic rst();
		reset <= 1'b1;
		motionP <= 1'b0;
		motionS <= 1'b0;
		lowPowerMode <= 1'b0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask
	// each pulse is one call of the sample handler
	task automatic wirq(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 20000) begin
			@(negedge clk);
			k++;
			if (sampleIrq === 1'b1) n--;
		end
		if (n > 0) begin
			n_errors++;
			$display("unexpected at %0t: sample interrupt missing", $time);
		end
		@(posedge clk);
	endtask
	task automatic t_regs();
		rst();
		chk8({6'h00, convContinuous, emiImmunity}, 8'h03);
		rd(RA, d);
		chk8(d, `PIRDC_CFG_A_RESET);
		rd(RB, d);
		chk8(d, `PIRDC_CFG_B_RESET);
		wr(RB, 8'hAD);
		rd(RB, d);
		chk8(d, 8'hAD);
		wr(RA, 8'h7B);
		rd(RA, d);
		chk8(d, 8'h7B);
		wr(9'h1F0, 8'hFF);
		rd(9'h1F0, d);
		chk8(d, 8'h00);
		$display("done regs");
	endtask
	task automatic t_tick();
		rst();
		nHk = 0;
		wr(RA, 8'h80);
		repeat (4) @(posedge clk);
		chkn(nHk, 1);
		rd(RA, d);
		chk8(d, 8'h00);
		$display("done tick");
	endtask
	task automatic t_normal();
		rst();
		wirq(1);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (sampleIrq !== 1'b1 && c < 1000);
		chkn(c, `PIRDC_NORMAL_CYC);
		chk8({6'h00, selPrimary, selSecond}, 8'h02);
		@(posedge clk);
		$display("done normal");
	endtask
	task automatic t_low();
		rst();
		wr(RA, 8'h04);
		rd(RS, d);
		chk8(d & 8'h04, 8'h04);
		chk8({5'h00, convContinuous, emiImmunity, convPowerOn}, 8'h00);
		repeat (SETC + 10) @(posedge clk);
		rd(RS, d);
		chk8(d & 8'h04, 8'h00);
		nEv = 0;
		motionP <= 1'b1;
		convStartReq <= 1'b1;
		@(posedge clk);
		convStartReq <= 1'b0;
		c = 0;
		@(negedge clk);
		while (convPowerOn === 1'b1 && c < 10000) begin
			c++;
			@(negedge clk);
		end
		chkn(c, LOWC);
		chk8({7'h00, sampleIrq}, 8'h01);
		repeat (20) @(negedge clk);
		chk8({7'h00, convPowerOn}, 8'h00);
		chkn(nEv, 1);
		@(posedge clk);
		$display("done low");
	endtask
	task automatic t_motion(input logic [7:0] cfg, input logic onS, input logic want);
		rst();
		nEv = 0;
		wr(RA, cfg);
		motionP <= ~onS;
		motionS <= onS;
		wirq(6);
		chk8({7'h00, motionDetected}, {7'h00, want});
		chkn(nEv, int'(want));
		wr(RS, 8'h01);
		rd(RS, d);
		chk8(d & 8'h01, 8'h00);
		$display("done motion");
	endtask
	task automatic t_light();
		rst();
		nLt = 0;
		wr(RA, 8'h80);
		wirq(3);
		chkn(nLt, 0);
		wr(RB, 8'h08);
		lowPowerMode <= 1'b1;
		wr(RA, 8'h80);
		wirq(3);
		chkn(nLt, 0);
		lowPowerMode <= 1'b0;
		nBuf = 0;
		wr(RA, 8'h80);
		wirq(3);
		chkn(nLt, `PIRDC_NORMAL_CYC);
		chkn(nBuf, `PIRDC_NORMAL_CYC);
		lightLevel <= 12'h300;
		wr(RA, 8'h80);
		wirq(3);
		chk8({7'h00, lightChanged}, 8'h01);
		$display("done light");
	endtask
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#600000;
		n_errors++;
		final_report();
	end
	initial begin
		t_regs();
		t_tick();
		t_normal();
		t_low();
		t_motion(8'h78, 1'b0, 1'b1);
		t_motion(8'h7A, 1'b0, 1'b0);
		t_motion(8'h78, 1'b1, 1'b0);
		t_motion(8'h79, 1'b1, 1'b1);
		t_light();
		final_report();
	end
endmodule
`default_nettype wire
